// ==== common/flash_wp_params.svh ====
// Opcodes, register bit positions and reset values of the protect block
`ifndef FLASH_WP_PARAMS_SVH
`define FLASH_WP_PARAMS_SVH

// Commands that alter the array or a register
`define OP_PAGE_PROGRAM       8'h02
`define OP_QUAD_PROGRAM_A     8'h32
`define OP_QUAD_PROGRAM_B     8'h38
`define OP_SECTOR_ERASE_A     8'hd7
`define OP_SECTOR_ERASE_B     8'h20
`define OP_HALF_BLOCK_ERASE   8'h52
`define OP_FULL_BLOCK_ERASE   8'hd8
`define OP_WHOLE_ERASE_A      8'hc7
`define OP_WHOLE_ERASE_B      8'h60
`define OP_STATUS_WRITE       8'h01
`define OP_FUNCTION_WRITE     8'h42
`define OP_ROW_ERASE          8'h64
`define OP_ROW_PROGRAM        8'h62

// Status register bit positions
`define ST_BUSY               0
`define ST_LATCH              1
`define ST_LEVEL_LSB          2
`define ST_QUAD               6
`define ST_LOCK               7

// Function register bit positions
`define FN_RESERVED           0
`define FN_AREA               1
`define FN_PROG_SUSP          2
`define FN_ERASE_SUSP         3
`define FN_ROW_LSB            4

// Reset value of both registers
`define REG_RESET             8'h00

// Address fields: 64 KB block index and information row index
`define BLOCK_LSB             16
`define ROW_LSB               8

`endif

// ==== common/flash_wp_pkg.sv ====
// Types shared by the flash write-protect block
`default_nettype none
package flash_wp_pkg;

   typedef enum logic [1:0] {
      FSM_IDLE      = 2'b00,
      FSM_BUSY      = 2'b01,
      FSM_SUSPENDED = 2'b10
   } core_fsm_t;

   typedef enum logic [2:0] {
      KIND_PROGRAM      = 3'b000,
      KIND_QUAD_PROGRAM = 3'b001,
      KIND_SECTOR       = 3'b010,
      KIND_HALF_BLOCK   = 3'b011,
      KIND_FULL_BLOCK   = 3'b100,
      KIND_WHOLE_ARRAY  = 3'b101,
      KIND_ROW_ERASE    = 3'b110,
      KIND_ROW_PROGRAM  = 3'b111
   } op_kind_t;

   typedef struct packed {
      logic        rstMeta;
      logic        rstSync;
      logic        toggle;
      logic [7:0]  code;
      logic [23:0] addr;
      logic [7:0]  data;
   } link_state_t;

   typedef struct packed {
      logic        wpMeta;
      logic        wpSync;
      logic        holdMeta;
      logic        holdSync;
      logic        tglMeta;
      logic        tglSync;
      logic        tglSeen;
      logic        primed;
      core_fsm_t   fsm;
      logic        opIsErase;
      logic        writeEnableLatch;
      logic [3:0]  protectLevel;
      logic        quadEnable;
      logic        statusLock;
      logic        protectAreaSelect;
      logic        programSuspendedFlag;
      logic        eraseSuspendedFlag;
      logic [3:0]  infoRowLock;
      logic        arrayStart;
      op_kind_t    arrayKind;
      logic [23:0] arrayAddr;
      logic        cmdRejected;
      logic [7:0]  statusOut;
      logic [7:0]  functionOut;
      logic        quadDataLines;
      logic        holdActive;
   } core_state_t;

endpackage
`default_nettype wire

// ==== common/protect_check_if.sv ====
// Carrier between the register core and the protected-area checker
`default_nettype none
interface protect_check_if #(
   parameter int BLOCK_BITS = 7
);
   logic [3:0]            protectLevel;
   logic                  protectAreaSelect;
   logic [BLOCK_BITS-1:0] blockIndex;
   logic                  inProtectedArea;

   modport asker (
      output protectLevel,
      output protectAreaSelect,
      output blockIndex,
      input  inProtectedArea
   );

   modport judge (
      input  protectLevel,
      input  protectAreaSelect,
      input  blockIndex,
      output inProtectedArea
   );
endinterface
`default_nettype wire

// ==== hdl/protect_range_check.sv ====
// Decides whether a 64 KB block lies in the protected area
`default_nettype none
module protect_range_check #(
   parameter int BLOCK_BITS = 7
) (
   // Level, area select and block index in, verdict out
   protect_check_if.judge pc
);
   import flash_wp_pkg::*;

   localparam logic [BLOCK_BITS:0] BLOCK_TOTAL =
      (BLOCK_BITS + 1)'(1) << BLOCK_BITS;

   logic [BLOCK_BITS:0] span;
   logic [BLOCK_BITS:0] index;
   logic                inSpan;

   // Level n covers 2^(n-1) blocks, zero covers none
   always_comb begin
      span  = '0;
      index = {1'b0, pc.blockIndex};
      if (pc.protectLevel[2:0] != 3'h0) begin
         span = (BLOCK_BITS + 1)'(1) << (pc.protectLevel[2:0] - 3'h1);
      end
      if (pc.protectAreaSelect) begin
         inSpan = index < span;
      end else begin
         inSpan = (span != '0) && (index >= BLOCK_TOTAL - span);
      end
   end

   // Top level bit overrides area and lower bits
   assign pc.inProtectedArea = pc.protectLevel[3] | inSpan;

endmodule
`default_nettype wire

// ==== hdl/flash_write_protect_regs.sv ====
// Write-protect logic with status and function registers of a serial flash
//
// Functional notes
// - Write commands need write-enable latch set first
// - Program or erase inside protected area inhibited
// - Whole-array erase only with all level bits zero
// - Lock plus low protect pin, quad off, freezes level, quad and lock bits
// - Status writable when unlocked or pin high
// - Quad enable turns protect/hold pins into data
// - Level n protects 2^(n-1) blocks, top/bottom
// - Top level bit set protects every block
// - Function register resets zero, fixed bit layout
// - One-time bits never return to zero
// - Area select defaults top, bottom is permanent
// - Suspend during program sets program flag
// - Suspend during erase sets erase flag
// - Locked information row refuses programming
// - Latch set, cleared by command or completion
// - Write commands without latch are ignored
// - Status layout busy, latch, level, quad, lock
`include "flash_wp_params.svh"
`default_nettype none
module flash_write_protect_regs #(
   // Opcodes held outside the command table; values are arbitrary
   parameter logic [7:0] WRITE_ENABLE_OP  = 8'hf1,
   parameter logic [7:0] WRITE_DISABLE_OP = 8'hf2,
   parameter logic [7:0] SUSPEND_OP       = 8'hf3,
   parameter logic [7:0] RESUME_OP        = 8'hf4,
   parameter int         BLOCK_BITS       = 7
) (
   // Core clock, reset and enable
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  clkEn,
   // Decoded command from the serial front end
   input  wire logic                  linkClk,
   input  wire logic                  cmdStrobe,
   input  wire logic [7:0]            cmdCode,
   input  wire logic [23:0]           cmdAddr,
   input  wire logic [7:0]            cmdData,
   // Package pins
   input  wire logic                  writeProtect_n,
   input  wire logic                  hold_n,
   // Array sequencer
   input  wire logic                  arrayDone,
   output logic                       arrayStart,
   output flash_wp_pkg::op_kind_t     arrayKind,
   output logic [23:0]                arrayAddr,
   // Register images and pin roles
   output logic [7:0]                 statusByte,
   output logic [7:0]                 functionByte,
   output logic                       cmdRejected,
   output logic                       quadDataLines,
   output logic                       holdActive
);
   import flash_wp_pkg::*;

   link_state_t lnk;
   link_state_t next_lnk;
   core_state_t cs;
   core_state_t next_cs;

   logic        newCmd;
   logic        pinLockActive;
   logic [1:0]  rowIndex;
   logic        arrayRefused;
   logic        enableCmd;

   protect_check_if #(.BLOCK_BITS(BLOCK_BITS)) pc ();

   // Command classes
   function automatic logic isProgram(input logic [7:0] c);
      return c == `OP_PAGE_PROGRAM || c == `OP_QUAD_PROGRAM_A ||
             c == `OP_QUAD_PROGRAM_B;
   endfunction

   function automatic logic isWholeArray(input logic [7:0] c);
      return c == `OP_WHOLE_ERASE_A || c == `OP_WHOLE_ERASE_B;
   endfunction

   function automatic logic isBlockErase(input logic [7:0] c);
      return c == `OP_SECTOR_ERASE_A || c == `OP_SECTOR_ERASE_B ||
             c == `OP_HALF_BLOCK_ERASE || c == `OP_FULL_BLOCK_ERASE;
   endfunction

   function automatic logic needsLatch(input logic [7:0] c);
      return isProgram(c) || isBlockErase(c) || isWholeArray(c) ||
             c == `OP_STATUS_WRITE || c == `OP_FUNCTION_WRITE ||
             c == `OP_ROW_ERASE || c == `OP_ROW_PROGRAM;
   endfunction

   function automatic op_kind_t kindOf(input logic [7:0] c);
      case (c)
         `OP_PAGE_PROGRAM:     return KIND_PROGRAM;
         `OP_QUAD_PROGRAM_A:   return KIND_QUAD_PROGRAM;
         `OP_QUAD_PROGRAM_B:   return KIND_QUAD_PROGRAM;
         `OP_SECTOR_ERASE_A:   return KIND_SECTOR;
         `OP_SECTOR_ERASE_B:   return KIND_SECTOR;
         `OP_HALF_BLOCK_ERASE: return KIND_HALF_BLOCK;
         `OP_FULL_BLOCK_ERASE: return KIND_FULL_BLOCK;
         `OP_ROW_ERASE:        return KIND_ROW_ERASE;
         `OP_ROW_PROGRAM:      return KIND_ROW_PROGRAM;
         default:              return KIND_WHOLE_ARRAY;
      endcase
   endfunction

   // Link side: catch each command and flip the event toggle.
   // Fields stay put until the next strobe, so the core may read
   // them once the toggle has crossed.
   always_comb begin
      next_lnk         = lnk;
      next_lnk.rstMeta = rst_n;
      next_lnk.rstSync = lnk.rstMeta;
      if (!lnk.rstSync) begin
         next_lnk.toggle = 1'b0;
      end else if (cmdStrobe) begin
         next_lnk.toggle = ~lnk.toggle;
         next_lnk.code   = cmdCode;
         next_lnk.addr   = cmdAddr;
         next_lnk.data   = cmdData;
      end
   end

   always_ff @(posedge linkClk) begin
      lnk <= next_lnk;
   end

   // Protected-area check on the addressed 64 KB block
   assign pc.protectLevel      = cs.protectLevel;
   assign pc.protectAreaSelect = cs.protectAreaSelect;
   assign pc.blockIndex        = lnk.addr[`BLOCK_LSB +: BLOCK_BITS];

   protect_range_check #(.BLOCK_BITS(BLOCK_BITS)) rangeCheck (
      .pc (pc)
   );

   // Event seen once the synchronised toggle differs from the last one
   assign newCmd = cs.primed && (cs.tglSync != cs.tglSeen);

   // Enable seen this cycle; it outlasts a same-cycle completion
   assign enableCmd = newCmd && lnk.code == WRITE_ENABLE_OP;

   // Protect pin only counts while it is not a data line
   assign pinLockActive = !cs.quadEnable && !cs.wpSync;

   assign rowIndex = lnk.addr[`ROW_LSB +: 2];

   // Refusal of an array command that already holds the latch
   always_comb begin
      if (isWholeArray(lnk.code)) begin
         arrayRefused = cs.protectLevel != 4'h0;
      end else if (lnk.code == `OP_ROW_PROGRAM) begin
         arrayRefused = cs.infoRowLock[rowIndex];
      end else if (lnk.code == `OP_ROW_ERASE) begin
         arrayRefused = 1'b0;
      end else begin
         arrayRefused = pc.inProtectedArea;
      end
   end

   // Core next state: commands, suspend and completion
   always_comb begin
      next_cs             = cs;
      next_cs.wpMeta      = writeProtect_n;
      next_cs.wpSync      = cs.wpMeta;
      next_cs.holdMeta    = hold_n;
      next_cs.holdSync    = cs.holdMeta;
      next_cs.tglMeta     = lnk.toggle;
      next_cs.tglSync     = cs.tglMeta;
      next_cs.tglSeen     = cs.tglSync;
      next_cs.primed      = 1'b1;
      next_cs.arrayStart  = 1'b0;
      next_cs.cmdRejected = 1'b0;
      if (newCmd) begin
         if (lnk.code == WRITE_ENABLE_OP) begin
            next_cs.writeEnableLatch = 1'b1;
         end else if (lnk.code == WRITE_DISABLE_OP) begin
            next_cs.writeEnableLatch = 1'b0;
         end else if (lnk.code == SUSPEND_OP) begin
            // Completion in the same cycle wins over the suspend
            if (cs.fsm == FSM_BUSY && !arrayDone) begin
               next_cs.fsm = FSM_SUSPENDED;
               if (cs.opIsErase) begin
                  next_cs.eraseSuspendedFlag = 1'b1;
               end else begin
                  next_cs.programSuspendedFlag = 1'b1;
               end
            end
         end else if (lnk.code == RESUME_OP) begin
            if (cs.fsm == FSM_SUSPENDED) begin
               next_cs.fsm                  = FSM_BUSY;
               next_cs.programSuspendedFlag = 1'b0;
               next_cs.eraseSuspendedFlag   = 1'b0;
            end
         end else if (needsLatch(lnk.code)) begin
            // No new write while one is running or suspended
            if (!cs.writeEnableLatch || cs.fsm != FSM_IDLE) begin
               next_cs.cmdRejected = 1'b1;
            end else begin
               case (lnk.code)
                  `OP_STATUS_WRITE: begin
                     if (cs.statusLock && pinLockActive) begin
                        next_cs.cmdRejected = 1'b1;
                     end else begin
                        next_cs.protectLevel =
                           lnk.data[`ST_LEVEL_LSB +: 4];
                        next_cs.quadEnable = lnk.data[`ST_QUAD];
                        next_cs.statusLock = lnk.data[`ST_LOCK];
                        next_cs.writeEnableLatch = 1'b0;
                     end
                  end
                  `OP_FUNCTION_WRITE: begin
                     // One-time bits can only be added, never removed
                     next_cs.protectAreaSelect = cs.protectAreaSelect |
                        lnk.data[`FN_AREA];
                     next_cs.infoRowLock = cs.infoRowLock |
                        lnk.data[`FN_ROW_LSB +: 4];
                     next_cs.writeEnableLatch = 1'b0;
                  end
                  default: begin
                     if (arrayRefused) begin
                        next_cs.cmdRejected = 1'b1;
                     end else begin
                        next_cs.fsm        = FSM_BUSY;
                        next_cs.arrayStart = 1'b1;
                        next_cs.arrayKind  = kindOf(lnk.code);
                        next_cs.arrayAddr  = lnk.addr;
                        next_cs.opIsErase  = !(isProgram(lnk.code) ||
                           lnk.code == `OP_ROW_PROGRAM);
                     end
                  end
               endcase
            end
         end
      end
      // Completion ends the write; an enable in the same cycle wins
      if (cs.fsm == FSM_BUSY && arrayDone) begin
         next_cs.fsm = FSM_IDLE;
         if (!enableCmd) begin
            next_cs.writeEnableLatch = 1'b0;
         end
      end
      // Register images built from the next values
      next_cs.statusOut[`ST_BUSY]             = next_cs.fsm == FSM_BUSY;
      next_cs.statusOut[`ST_LATCH]            = next_cs.writeEnableLatch;
      next_cs.statusOut[`ST_LEVEL_LSB +: 4]   = next_cs.protectLevel;
      next_cs.statusOut[`ST_QUAD]             = next_cs.quadEnable;
      next_cs.statusOut[`ST_LOCK]             = next_cs.statusLock;
      next_cs.functionOut[`FN_RESERVED]       = 1'b0;
      next_cs.functionOut[`FN_AREA]           = next_cs.protectAreaSelect;
      next_cs.functionOut[`FN_PROG_SUSP]      = next_cs.programSuspendedFlag;
      next_cs.functionOut[`FN_ERASE_SUSP]     = next_cs.eraseSuspendedFlag;
      next_cs.functionOut[`FN_ROW_LSB +: 4]   = next_cs.infoRowLock;
      next_cs.quadDataLines = next_cs.quadEnable;
      next_cs.holdActive = !next_cs.quadEnable && !cs.holdSync;
   end

   // Core register; clearing to zero gives every reset default
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cs <= '0;
      end else if (clkEn) begin
         cs <= next_cs;
      end
   end

   // Outputs straight from core flops
   assign arrayStart    = cs.arrayStart;
   assign arrayKind     = cs.arrayKind;
   assign arrayAddr     = cs.arrayAddr;
   assign statusByte    = cs.statusOut;
   assign functionByte  = cs.functionOut;
   assign cmdRejected   = cs.cmdRejected;
   assign quadDataLines = cs.quadDataLines;
   assign holdActive    = cs.holdActive;

   // Checks in the core domain
   default clocking coreClk @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   latch_gates_start_a: assert property (
      arrayStart |-> statusByte[`ST_LATCH] && statusByte[`ST_BUSY])
      else $error("array started without write-enable latch");

   protected_block_a: assert property (
      $rose(arrayStart) && arrayKind inside {KIND_PROGRAM,
         KIND_QUAD_PROGRAM, KIND_SECTOR, KIND_HALF_BLOCK,
         KIND_FULL_BLOCK} |-> !$past(pc.inProtectedArea))
      else $error("program or erase started in protected area");

   whole_erase_gate_a: assert property (
      arrayStart && arrayKind == KIND_WHOLE_ARRAY |->
         statusByte[`ST_LEVEL_LSB +: 4] == 4'h0)
      else $error("whole-array erase with protect level set");

   status_freeze_a: assert property (
      cs.statusLock && pinLockActive |=>
         $stable(statusByte[`ST_LOCK:`ST_LEVEL_LSB]))
      else $error("locked status bits changed");

   unlocked_write_a: assert property (
      newCmd && clkEn && lnk.code == `OP_STATUS_WRITE &&
         cs.writeEnableLatch && cs.fsm == FSM_IDLE && !cs.statusLock
         |=> statusByte[`ST_LOCK:`ST_LEVEL_LSB] ==
            $past(lnk.data[`ST_LOCK:`ST_LEVEL_LSB]))
      else $error("unlocked status write not applied");

   otp_sticky_a: assert property (
      ($past(functionByte[`FN_ROW_LSB +: 4]) &
         ~functionByte[`FN_ROW_LSB +: 4]) == 4'h0)
      else $error("row lock bit returned to zero");

   area_sticky_a: assert property (
      functionByte[`FN_AREA] |=> functionByte[`FN_AREA] [*8])
      else $error("area select returned to top");

   program_suspend_a: assert property (
      newCmd && clkEn && lnk.code == SUSPEND_OP &&
         cs.fsm == FSM_BUSY && !cs.opIsErase && !arrayDone
         |=> functionByte[`FN_PROG_SUSP] && !statusByte[`ST_BUSY])
      else $error("program suspend flag not set");

   suspend_resume_a: assert property (
      newCmd && clkEn && lnk.code == RESUME_OP &&
         cs.fsm == FSM_SUSPENDED
         |=> !functionByte[`FN_ERASE_SUSP] && !functionByte[`FN_PROG_SUSP]
            && statusByte[`ST_BUSY])
      else $error("suspend flags not cleared on resume");

   row_lock_a: assert property (
      $rose(arrayStart) && arrayKind == KIND_ROW_PROGRAM |->
         !functionByte[`FN_ROW_LSB + arrayAddr[`ROW_LSB +: 2]])
      else $error("locked information row programmed");

   done_clears_a: assert property (
      cs.fsm == FSM_BUSY && arrayDone && clkEn |=>
         statusByte[`ST_LATCH] == $past(enableCmd) &&
         !statusByte[`ST_BUSY])
      else $error("latch or busy kept after completion");

   reserved_zero_a: assert property (
      !functionByte[`FN_RESERVED])
      else $error("reserved function bit set");

   // Main scenarios
   program_start_c: cover property (
      $rose(arrayStart) && arrayKind == KIND_PROGRAM);
   erase_suspend_c: cover property (
      $rose(functionByte[`FN_ERASE_SUSP]));
   locked_reject_c: cover property (
      newCmd && lnk.code == `OP_STATUS_WRITE && cs.statusLock &&
      pinLockActive && cs.writeEnableLatch);
   bottom_area_c: cover property (
      $rose(functionByte[`FN_AREA]));

endmodule
`default_nettype wire

// ==== testbench/host_cmd_model.sv ====
// Host-side command source on its own link clock
`default_nettype none
module host_cmd_model (
   // Link clock and command fields
   output var logic        linkClk,
   output var logic        cmdStrobe,
   output var logic [7:0]  cmdCode,
   output var logic [23:0] cmdAddr,
   output var logic [7:0]  cmdData
);
   timeunit 1ns;
   timeprecision 100ps;

   // Free running, the core needs it during reset as well
   initial linkClk = 1'b0;
   always #15 linkClk = ~linkClk;

   // Idle values at time zero
   initial begin
      cmdStrobe = 1'b0;
      cmdCode   = 8'h00;
      cmdAddr   = 24'h000000;
      cmdData   = 8'h00;
   end

   // One strobe per command, fields stale-inverted after it
   task automatic send(input logic [7:0] c, input logic [23:0] a,
                       input logic [7:0] d);
      @(posedge linkClk);
      #1;
      cmdStrobe = 1'b1;
      cmdCode   = c;
      cmdAddr   = a;
      cmdData   = d;
      @(posedge linkClk);
      #1;
      cmdStrobe = 1'b0;
      // Inverted so nobody leans on old field values
      cmdCode   = ~c;
      cmdAddr   = ~a;
      cmdData   = ~d;
      // Spacing keeps strobes from being lost across domains
      repeat (3) @(posedge linkClk);
   endtask
endmodule
`default_nettype wire

// ==== testbench/flash_write_protect_regs_tb_top.sv ====
// Self-checking bench for the flash write-protect block
`include "flash_wp_params.svh"
`default_nettype none
module flash_write_protect_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import flash_wp_pkg::*;

   localparam logic [7:0] WE = 8'hf1;
   localparam logic [7:0] WD = 8'hf2;
   localparam logic [7:0] SUS = 8'hf3;
   localparam logic [7:0] RES = 8'hf4;
   localparam logic [7:0] SW = `OP_STATUS_WRITE;
   localparam logic [7:0] FW = `OP_FUNCTION_WRITE;
   localparam logic [7:0] PGM = `OP_PAGE_PROGRAM;

   logic        ref_clk = 1'b0;
   logic        rst_n, clkEn, writeProtect_n, hold_n, arrayDone;
   logic        linkClk, cmdStrobe, arrayStart, cmdRejected;
   logic        quadDataLines, holdActive;
   logic [7:0]  cmdCode, cmdData, statusByte, functionByte;
   logic [23:0] cmdAddr, arrayAddr;
   op_kind_t    arrayKind;
   logic [7:0]  rejCnt = 8'h00, startCnt = 8'h00;
   logic [7:0]  eRej = 8'h00, eStart = 8'h00;
   int          err_count = 0, check_count = 0;
   logic [7:0]  ops [11] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52,
                             8'hd8, 8'hc7, 8'h60, 8'h64, 8'h62};
   logic [2:0]  kinds [11] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3,
                               3'h4, 3'h5, 3'h5, 3'h6, 3'h7};

   always #2 ref_clk = ~ref_clk;

   host_cmd_model host (.linkClk(linkClk), .cmdStrobe(cmdStrobe),
      .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdData(cmdData));

   flash_write_protect_regs #(.WRITE_ENABLE_OP(WE), .WRITE_DISABLE_OP(WD),
      .SUSPEND_OP(SUS), .RESUME_OP(RES), .BLOCK_BITS(7)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
      .linkClk(linkClk), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
      .cmdAddr(cmdAddr), .cmdData(cmdData),
      .writeProtect_n(writeProtect_n), .hold_n(hold_n),
      .arrayDone(arrayDone), .arrayStart(arrayStart),
      .arrayKind(arrayKind), .arrayAddr(arrayAddr),
      .statusByte(statusByte), .functionByte(functionByte),
      .cmdRejected(cmdRejected), .quadDataLines(quadDataLines),
      .holdActive(holdActive));

   // One-cycle pulses are counted so no edge is missed
   always @(posedge ref_clk) begin
      if (cmdRejected === 1'b1) rejCnt <= rejCnt + 8'h01;
      if (arrayStart === 1'b1) startCnt <= startCnt + 8'h01;
   end

   task automatic chk(input string n, input logic [23:0] e,
                      input logic [23:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // Host command, then realign to the core clock
   task automatic cmd(input logic [7:0] c, input logic [23:0] a,
                      input logic [7:0] d);
      host.send(c, a, d);
      @(posedge ref_clk);
      #1;
   endtask

   // Enable then command; how: 0 refused, 1 register, 2 array start
   task automatic wcmd(input logic [7:0] c, input logic [23:0] a,
                       input logic [7:0] d, input int how);
      cmd(WE, 24'h000000, 8'h00);
      cmd(c, a, d);
      if (how == 2) eStart = eStart + 8'h01;
      if (how == 0) eRej = eRej + 8'h01;
      chk("starts", 24'(eStart), 24'(startCnt));
      chk("rejects", 24'(eRej), 24'(rejCnt));
   endtask

   // Sequencer finishes; busy and latch must drop
   task automatic fin(input logic [7:0] s);
      arrayDone = 1'b1;
      @(posedge ref_clk);
      #1;
      arrayDone = 1'b0;
      @(posedge ref_clk);
      #1;
      chk("status", 24'(s), 24'(statusByte));
   endtask

   task automatic close_out();
      $display("Checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Whole run is roughly ten microseconds
   initial begin
      #200us;
      err_count++;
      close_out();
   end

   initial begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      writeProtect_n = 1'b1;
      hold_n = 1'b1;
      arrayDone = 1'b0;
      // Long enough for both domains to see reset
      repeat (5) @(posedge linkClk);
      @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge linkClk);
      @(posedge ref_clk);
      #1;
      chk("status", 24'h0, 24'(statusByte));
      chk("function", 24'h0, 24'(functionByte));
      cmd(PGM, 24'h000000, 8'h00);
      eRej = eRej + 8'h01;
      chk("rejects", 24'(eRej), 24'(rejCnt));
      cmd(WE, 24'h000000, 8'h00);
      chk("status", 24'h02, 24'(statusByte));
      cmd(WD, 24'h000000, 8'h00);
      chk("status", 24'h00, 24'(statusByte));
      // Frozen core keeps the enable pending until clkEn returns
      clkEn = 1'b0;
      cmd(WE, 24'h000000, 8'h00);
      chk("status", 24'h00, 24'(statusByte));
      clkEn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      chk("status", 24'h02, 24'(statusByte));
      cmd(WD, 24'h000000, 8'h00);
      chk("status", 24'h00, 24'(statusByte));
      // Every latch-needing array command, in turn
      for (int i = 0; i < 11; i++) begin
         wcmd(ops[i], 24'h7f0100, 8'h00, 2);
         chk("kind", 24'(kinds[i]), 24'(arrayKind));
         chk("addr", 24'h7f0100, arrayAddr);
         chk("status", 24'h03, 24'(statusByte));
         fin(8'h00);
      end
      wcmd(PGM, 24'h000200, 8'h00, 2);
      cmd(SUS, 24'h000000, 8'h00);
      chk("function", 24'h04, 24'(functionByte));
      cmd(RES, 24'h000000, 8'h00);
      chk("function", 24'h00, 24'(functionByte));
      fin(8'h00);
      wcmd(`OP_SECTOR_ERASE_B, 24'h001000, 8'h00, 2);
      cmd(SUS, 24'h000000, 8'h00);
      chk("function", 24'h08, 24'(functionByte));
      cmd(RES, 24'h000000, 8'h00);
      chk("function", 24'h00, 24'(functionByte));
      fin(8'h00);
      // Level 3, top area: blocks 124 to 127
      wcmd(SW, 24'h000000, 8'h0c, 1);
      chk("status", 24'h0c, 24'(statusByte));
      wcmd(PGM, 24'h7c0000, 8'h00, 0);
      wcmd(PGM, 24'h7b0000, 8'h00, 2);
      fin(8'h0c);
      wcmd(`OP_WHOLE_ERASE_A, 24'h000000, 8'h00, 0);
      wcmd(SW, 24'h000000, 8'h20, 1);
      wcmd(PGM, 24'h000000, 8'h00, 0);
      // Read-only bits ignored, one-time bits stay set
      wcmd(FW, 24'h000000, 8'h1f, 1);
      chk("function", 24'h12, 24'(functionByte));
      wcmd(FW, 24'h000000, 8'h00, 1);
      chk("function", 24'h12, 24'(functionByte));
      // Level 1, bottom area: block 0 only
      wcmd(SW, 24'h000000, 8'h04, 1);
      wcmd(PGM, 24'h000000, 8'h00, 0);
      wcmd(PGM, 24'hff0000, 8'h00, 2);
      fin(8'h04);
      wcmd(`OP_ROW_PROGRAM, 24'h000000, 8'h00, 0);
      wcmd(`OP_ROW_PROGRAM, 24'h000100, 8'h00, 2);
      fin(8'h04);
      // Hardware lock with the protect pin
      hold_n = 1'b0;
      wcmd(SW, 24'h000000, 8'h84, 1);
      chk("status", 24'h84, 24'(statusByte));
      chk("holdActive", 24'h1, 24'(holdActive));
      writeProtect_n = 1'b0;
      wcmd(SW, 24'h000000, 8'h40, 0);
      chk("status", 24'h86, 24'(statusByte));
      writeProtect_n = 1'b1;
      wcmd(SW, 24'h000000, 8'h40, 1);
      chk("status", 24'h40, 24'(statusByte));
      chk("quadDataLines", 24'h1, 24'(quadDataLines));
      chk("holdActive", 24'h0, 24'(holdActive));
      wcmd(SW, 24'h000000, 8'h00, 1);
      chk("quadDataLines", 24'h0, 24'(quadDataLines));
      chk("holdActive", 24'h1, 24'(holdActive));
      close_out();
   end
endmodule
`default_nettype wire
